/* drive_fault_policy_unit.sv */
// Drive fault policy unit: per-condition policy, fault latching, manual clearing and Wishbone registers.
// How it works
// RL1 - Manual sources clear a fault only when it is active and not auto-reset.
// RL2 - Eight manual source choices from a three-bit mask; default pin or key.
// RL3 - With no source selected every manual request is ignored and faults stay.
// RL4 - Stop key clears only while the fault display shows and key is selected.
// RL5 - Input phase monitoring is disabled or fault; default fault.
// RL6 - DC bus feed shows a mains-missing notice, removed once phase monitoring is off.
// RL7 - An assigned external trip input is ignored, warns or faults; default disabled.
// RL8 - Motor overtemperature is disabled, warning or fault; default fault.
// RL9 - Reference loss: no action, keep last speed, switch to preset, or fault.
// RL10 - Preset mode switches to the loss frequency register, reset value zero.
// RL11 - Internal or external fan loss is disabled, warning or fault; default warning.
// RL12 - Warnings flag and keep running; faults flag and command a stop.
// RL13 - A fault stays latched with stop asserted until an enabled source clears it.
// RL14 - A warning shows while its condition lasts and never blocks running.
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module drive_fault_policy_unit
   import fault_policy_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Monitored conditions and manual requests
   input wire monitor_t monitor_i,
   input wire manual_t manual_i,
   input wire logic [FREQ_W-1:0] ref_speed_i,
   // Drive commands and flags
   output logic stop_cmd_o,
   output logic [NUM_COND-1:0] warn_o,
   output logic [NUM_COND-1:0] fault_o,
   output logic mains_missing_o,
   output logic [FREQ_W-1:0] speed_ref_o,
   output logic irq_o
);

   logic [CFG_W-1:0] cfg_reg;
   logic [CFG_W-1:0] cfg_next;
   logic [FREQ_W-1:0] loss_freq_reg;
   logic [FREQ_W-1:0] loss_freq_next;
   logic [IRQ_W-1:0] irq_status_reg;
   logic [IRQ_W-1:0] irq_status_next;
   logic [IRQ_W-1:0] irq_enable_reg;
   logic [IRQ_W-1:0] irq_enable_next;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic pin_prev_reg;
   logic key_prev_reg;
   logic [FREQ_W-1:0] held_speed_reg;
   logic [FREQ_W-1:0] speed_reg;
   logic [FREQ_W-1:0] speed_next;
   logic stop_reg;
   logic [NUM_COND-1:0] warn_reg;
   logic [NUM_COND-1:0] fault_reg;
   logic mains_reg;

   // Bus decode.
   wire access = wb_cyc_i && wb_stb_i && !ack_reg;
   wire wr_en = access && wb_we_i;
   wire sel_cfg = (wb_adr_i == CFG_OFFSET);
   wire sel_freq = (wb_adr_i == LOSS_FREQ_OFFSET);
   wire sel_status = (wb_adr_i == STATUS_OFFSET);
   wire sel_irq_status = (wb_adr_i == IRQ_STATUS_OFFSET);
   wire sel_irq_clear = (wb_adr_i == IRQ_CLEAR_OFFSET);
   wire sel_irq_enable = (wb_adr_i == IRQ_ENABLE_OFFSET);
   wire sel_serial = (wb_adr_i == SERIAL_CMD_OFFSET);
   wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wdata = wb_dat_i & wmask;

   // Configuration fields.
   wire clear_src_t clear_src = clear_src_t'(cfg_reg[CFG_SRC_LSB +: 3]);
   wire phase_enabled = cfg_reg[CFG_PHASE_BIT];
   wire policy_t ext_mode = policy_t'(cfg_reg[CFG_EXT_LSB +: 2]);
   wire policy_t motor_mode = policy_t'(cfg_reg[CFG_MOTOR_LSB +: 2]);
   wire ref_mode_t ref_mode = ref_mode_t'(cfg_reg[CFG_REF_LSB +: 2]);
   wire policy_t fan_mode = policy_t'(cfg_reg[CFG_FAN_LSB +: 2]);
   wire [NUM_COND-1:0] auto_en = cfg_reg[CFG_AUTO_LSB +: NUM_COND];

   // Pin and key requests are taken on their rising edge so a held input clears once.
   wire pin_req = manual_i.reset_pin && !pin_prev_reg;
   wire key_req = manual_i.stop_key && !key_prev_reg;
   wire serial_req = wr_en && sel_serial && wb_sel_i[0] && wb_dat_i[SER_RESET_BIT];

   // RL2 source mask decode
   wire by_pin = clear_src[0];
   wire by_key = clear_src[1];
   wire by_serial = clear_src[2];
   // RL4 key needs fault display
   wire key_clear = by_key && key_req && manual_i.fault_display;
   // RL3 empty mask never clears
   wire manual_clear = (clear_src != CLEAR_NONE) && ((by_pin && pin_req) || key_clear || (by_serial && serial_req));

   // Per-condition inputs and policies.
   logic [NUM_COND-1:0] cond_vec;
   policy_t mode_vec [NUM_COND];
   logic [NUM_COND-1:0] clear_vec;
   logic [NUM_COND-1:0] warn_vec;
   logic [NUM_COND-1:0] fault_vec;
   logic [NUM_COND-1:0] fault_set_vec;
   logic [NUM_COND-1:0] warn_rise_vec;

   // RL5 phase loss, muted on DC feed
   assign cond_vec[COND_PHASE] = monitor_i.phase_fail && !monitor_i.dc_bus_fed;
   assign mode_vec[COND_PHASE] = phase_enabled ? POLICY_FAULT : POLICY_DISABLED;
   // RL7 external trip when assigned
   assign cond_vec[COND_EXT_TRIP] = monitor_i.ext_trip && monitor_i.ext_trip_assigned;
   assign mode_vec[COND_EXT_TRIP] = ext_mode;
   // RL8 motor overtemperature
   assign cond_vec[COND_MOTOR_HOT] = monitor_i.motor_hot;
   assign mode_vec[COND_MOTOR_HOT] = motor_mode;
   // RL9 reference loss fault
   assign cond_vec[COND_REF_LOSS] = monitor_i.ref_lost;
   assign mode_vec[COND_REF_LOSS] = (ref_mode == REF_FAULT) ? POLICY_FAULT : POLICY_DISABLED;
   // RL11 either cooling fan
   assign cond_vec[COND_FAN_LOSS] = monitor_i.fan_int_lost || monitor_i.fan_ext_lost;
   assign mode_vec[COND_FAN_LOSS] = fan_mode;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_COND; gi++) begin : g_cell
         // RL1 manual only without auto-reset
         assign clear_vec[gi] = auto_en[gi] ? manual_i.auto_clear[gi] : (manual_clear && fault_vec[gi]);
         policy_cell u_cell (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cond_i(cond_vec[gi]),
            .mode_i(mode_vec[gi]),
            .clear_i(clear_vec[gi]),
            .warn_o(warn_vec[gi]),
            .fault_o(fault_vec[gi]),
            .fault_set_o(fault_set_vec[gi]),
            .warn_rise_o(warn_rise_vec[gi])
         );
      end
   endgenerate

   // RL6 mains-missing notice
   wire mains_next = monitor_i.dc_bus_fed && phase_enabled;

   // RL9 speed reference selection
   wire retain_active = monitor_i.ref_lost && (ref_mode == REF_RETAIN);
   // RL10 preset loss frequency
   wire preset_active = monitor_i.ref_lost && (ref_mode == REF_PRESET);
   assign speed_next = retain_active ? held_speed_reg : (preset_active ? loss_freq_reg : ref_speed_i);

   // Register writes; sticky interrupt sets win over a clear in the same cycle.
   wire [IRQ_W-1:0] irq_events = {warn_rise_vec, fault_set_vec};
   wire [IRQ_W-1:0] irq_clear = (wr_en && sel_irq_clear) ? wdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
   assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
   assign cfg_next = (wr_en && sel_cfg) ? ((cfg_reg & ~wmask[CFG_W-1:0]) | wdata[CFG_W-1:0]) : cfg_reg;
   assign loss_freq_next = (wr_en && sel_freq) ?
      ((loss_freq_reg & ~wmask[FREQ_W-1:0]) | wdata[FREQ_W-1:0]) : loss_freq_reg;
   assign irq_enable_next = (wr_en && sel_irq_enable) ?
      ((irq_enable_reg & ~wmask[IRQ_W-1:0]) | wdata[IRQ_W-1:0]) : irq_enable_reg;

   // Read data; clear and serial registers are write-only and read zero like unmapped space.
   wire [31:0] status_word = {18'h00000, preset_active, retain_active, mains_reg, stop_reg, fault_reg, warn_reg};
   wire [31:0] rd_mux = sel_cfg ? {15'h0000, cfg_reg} :
                        sel_freq ? {16'h0000, loss_freq_reg} :
                        sel_status ? status_word :
                        sel_irq_status ? {22'h000000, irq_status_reg} :
                        sel_irq_enable ? {22'h000000, irq_enable_reg} :
                        32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= CFG_RESET;
         loss_freq_reg <= LOSS_FREQ_RESET;
         irq_status_reg <= {IRQ_W{1'b0}};
         irq_enable_reg <= IRQ_ENABLE_RESET;
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         cfg_reg <= cfg_next;
         loss_freq_reg <= loss_freq_next;
         irq_status_reg <= irq_status_next;
         irq_enable_reg <= irq_enable_next;
         ack_reg <= access;
         dat_reg <= (access && !wb_we_i) ? rd_mux : dat_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_prev_reg <= 1'b0;
         key_prev_reg <= 1'b0;
         held_speed_reg <= {FREQ_W{1'b0}};
         speed_reg <= {FREQ_W{1'b0}};
      end else begin
         pin_prev_reg <= manual_i.reset_pin;
         key_prev_reg <= manual_i.stop_key;
         held_speed_reg <= monitor_i.ref_lost ? held_speed_reg : ref_speed_i;
         speed_reg <= speed_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_reg <= 1'b0;
         warn_reg <= {NUM_COND{1'b0}};
         fault_reg <= {NUM_COND{1'b0}};
         mains_reg <= 1'b0;
      end else begin
         // RL12 stop from any fault
         stop_reg <= |fault_vec;
         // RL14 warnings never stop
         warn_reg <= warn_vec;
         fault_reg <= fault_vec;
         mains_reg <= mains_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign stop_cmd_o = stop_reg;
   assign warn_o = warn_reg;
   assign fault_o = fault_reg;
   assign mains_missing_o = mains_reg;
   assign speed_ref_o = speed_reg;
   assign irq_o = |(irq_status_reg & irq_enable_reg);

   sequence s_fault_held;
      fault_vec[COND_MOTOR_HOT] && !auto_en[COND_MOTOR_HOT];
   endsequence

   sequence s_key_no_display;
      key_req && !manual_i.fault_display && !pin_req && !serial_req;
   endsequence

   chk_none_keeps_fault: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
      s_fault_held ##0 (clear_src == CLEAR_NONE) ##0 !cond_vec[COND_MOTOR_HOT] |=> fault_vec[COND_MOTOR_HOT])
      else $error("fault cleared with no manual source selected");
   chk_key_needs_display: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
      s_fault_held ##0 s_key_no_display |=> fault_vec[COND_MOTOR_HOT])
      else $error("stop key cleared a fault without the fault display");
   chk_pin_clears_fault: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
      s_fault_held ##0 by_pin ##0 pin_req ##0 !cond_vec[COND_MOTOR_HOT] |=> !fault_vec[COND_MOTOR_HOT])
      else $error("selected input pin did not clear the fault");
   chk_auto_blocks_manual: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
      fault_vec[COND_MOTOR_HOT] && auto_en[COND_MOTOR_HOT] && !manual_i.auto_clear[COND_MOTOR_HOT]
      |=> fault_vec[COND_MOTOR_HOT]) else $error("manual source cleared an auto-reset fault");
   chk_stop_follows_fault: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
      (|fault_vec) |=> stop_cmd_o)
      else $error("stop command did not follow a latched fault");
   chk_warn_no_stop: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
      (|warn_vec) && !(|fault_vec) |=> warn_o == $past(warn_vec) && !stop_cmd_o)
      else $error("warning stopped the drive or was not reported");
   chk_mains_notice: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
      monitor_i.dc_bus_fed && !phase_enabled |=> !mains_missing_o)
      else $error("mains-missing notice shown with phase monitoring off");
   chk_dc_feed_no_fault: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
      monitor_i.dc_bus_fed && !fault_vec[COND_PHASE] |=> !fault_vec[COND_PHASE])
      else $error("phase fault raised on a DC bus feed");
   chk_preset_speed: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
      preset_active |=> speed_ref_o == $past(loss_freq_reg))
      else $error("preset mode did not select the loss frequency");
   chk_retain_speed: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
      !monitor_i.ref_lost ##1 (retain_active [*2]) |=> speed_ref_o == $past(ref_speed_i, 3))
      else $error("retain mode lost the last reference speed");
   chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("acknowledge held longer than one cycle");
   chk_ack_after_take: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request taken without an acknowledge");
   chk_serial_clears_fault: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
      s_fault_held ##0 by_serial ##0 serial_req ##0 !cond_vec[COND_MOTOR_HOT] |=> !fault_vec[COND_MOTOR_HOT])
      else $error("selected serial command did not clear the fault");
   chk_phase_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
      !phase_enabled && !fault_vec[COND_PHASE] |=> !fault_vec[COND_PHASE])
      else $error("phase fault raised with phase monitoring disabled");
   chk_ext_unassigned: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
      !monitor_i.ext_trip_assigned && !fault_vec[COND_EXT_TRIP] |=> !fault_vec[COND_EXT_TRIP])
      else $error("external trip raised while no input is assigned");

endmodule : drive_fault_policy_unit

/* fault_policy_pkg.sv */
// Constants, types and register layout shared by the drive fault policy unit.
package fault_policy_pkg;

   // Register byte offsets on the Wishbone bus.
   localparam logic [7:0] CFG_OFFSET = 8'h00;
   localparam logic [7:0] LOSS_FREQ_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
   localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h10;
   localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h14;
   localparam logic [7:0] SERIAL_CMD_OFFSET = 8'h18;

   // Monitored conditions, one policy cell each.
   localparam int NUM_COND = 5;
   localparam int COND_PHASE = 0;
   localparam int COND_EXT_TRIP = 1;
   localparam int COND_MOTOR_HOT = 2;
   localparam int COND_REF_LOSS = 3;
   localparam int COND_FAN_LOSS = 4;

   // Configuration register fields.
   localparam int CFG_W = 17;
   localparam int CFG_SRC_LSB = 0;
   localparam int CFG_PHASE_BIT = 3;
   localparam int CFG_EXT_LSB = 4;
   localparam int CFG_MOTOR_LSB = 6;
   localparam int CFG_REF_LSB = 8;
   localparam int CFG_FAN_LSB = 10;
   localparam int CFG_AUTO_LSB = 12;
   // Sources pin or key, phase fault, external disabled, motor fault, no action, fan warning.
   localparam logic [16:0] CFG_RESET = 17'h0048B;

   // Loss frequency register.
   localparam int FREQ_W = 16;
   localparam logic [15:0] LOSS_FREQ_RESET = 16'h0000;

   // Status register fields.
   localparam int STS_WARN_LSB = 0;
   localparam int STS_FAULT_LSB = 5;
   localparam int STS_STOP_BIT = 10;
   localparam int STS_MAINS_BIT = 11;
   localparam int STS_RETAIN_BIT = 12;
   localparam int STS_PRESET_BIT = 13;

   // Interrupt bits: fault raised per condition, then warning onset per condition.
   localparam int IRQ_W = 10;
   localparam int IRQ_FAULT_LSB = 0;
   localparam int IRQ_WARN_LSB = 5;
   localparam logic [9:0] IRQ_ENABLE_RESET = 10'h000;

   localparam int SER_RESET_BIT = 0;

   typedef enum logic [1:0] {
      POLICY_DISABLED = 2'b00,
      POLICY_WARNING = 2'b01,
      POLICY_FAULT = 2'b10
   } policy_t;

   typedef enum logic [1:0] {
      REF_NO_ACTION = 2'b00,
      REF_RETAIN = 2'b01,
      REF_PRESET = 2'b10,
      REF_FAULT = 2'b11
   } ref_mode_t;

   // Bit 0 digital input, bit 1 stop key, bit 2 serial command.
   typedef enum logic [2:0] {
      CLEAR_NONE = 3'b000,
      CLEAR_BY_INPUT_PIN = 3'b001,
      CLEAR_BY_STOP_KEY = 3'b010,
      CLEAR_BY_PIN_OR_KEY = 3'b011,
      CLEAR_BY_SERIAL_CMD = 3'b100,
      CLEAR_BY_PIN_OR_SERIAL = 3'b101,
      CLEAR_BY_KEY_OR_SERIAL = 3'b110,
      CLEAR_BY_ANY_SOURCE = 3'b111
   } clear_src_t;

   typedef struct packed {
      logic phase_fail;
      logic dc_bus_fed;
      logic ext_trip_assigned;
      logic ext_trip;
      logic motor_hot;
      logic ref_lost;
      logic fan_int_lost;
      logic fan_ext_lost;
   } monitor_t;

   typedef struct packed {
      logic reset_pin;
      logic stop_key;
      logic fault_display;
      logic [4:0] auto_clear;
   } manual_t;

endpackage : fault_policy_pkg

/* policy_cell.sv */
// One monitored condition: warning level and latched stopping fault.
`timescale 1ns/1ps
module policy_cell
   import fault_policy_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Condition and policy
   input wire logic cond_i,
   input wire policy_t mode_i,
   input wire logic clear_i,
   // Results
   output logic warn_o,
   output logic fault_o,
   output logic fault_set_o,
   output logic warn_rise_o
);

   logic fault_reg;
   logic fault_next;
   logic warn_prev_reg;
   logic trip;

   // RL14 warning follows condition
   assign warn_o = cond_i && (mode_i == POLICY_WARNING);
   // RL12 fault outcome trips
   assign trip = cond_i && (mode_i == POLICY_FAULT);
   // RL13 latched until cleared; a trip in the clearing cycle wins.
   assign fault_next = trip || (fault_reg && !clear_i);
   assign fault_set_o = trip && !fault_reg;
   assign warn_rise_o = warn_o && !warn_prev_reg;
   assign fault_o = fault_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_reg <= 1'b0;
         warn_prev_reg <= 1'b0;
      end else begin
         fault_reg <= fault_next;
         warn_prev_reg <= warn_o;
      end
   end

   chk_fault_stays_latched: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
      fault_o && !clear_i |=> fault_o) else $error("latched fault dropped without a clear");
   chk_warning_never_latches: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
      !fault_o && mode_i != POLICY_FAULT |=> !fault_o) else $error("fault latched outside fault policy");
   chk_trip_beats_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
      cond_i && mode_i == POLICY_FAULT && clear_i |=> fault_o) else $error("clear swallowed a trip");

endmodule : policy_cell

/* far_side_model.sv */
// Far side model: monitored condition levels, reset pin, keypad stop key and fault display.
`timescale 1ns/1ps
module far_side_model
   import fault_policy_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Levels towards the block
   output monitor_t monitor_o,
   output manual_t manual_o
);
   initial begin
      monitor_o = '0;
      manual_o = '0;
      manual_o.fault_display = 1'b1;
   end

   // Pin and key act on their rising edge, so each press is released before the next one.
   task automatic press(input logic key);
      @(posedge clk_i);
      if (key)
         manual_o.stop_key <= 1'b1;
      else
         manual_o.reset_pin <= 1'b1;
      @(posedge clk_i);
      manual_o.stop_key <= 1'b0;
      manual_o.reset_pin <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : press
endmodule : far_side_model

/* test_drive_fault_policy_unit.sv */
// Self-checking bench for the drive fault policy unit.
`timescale 1ns/1ps
module test_drive_fault_policy_unit
   import fault_policy_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   monitor_t monitor_i;
   manual_t manual_i;
   logic [15:0] ref_speed_i;
   logic stop_cmd_o;
   logic [4:0] warn_o;
   logic [4:0] fault_o;
   logic mains_missing_o;
   logic [15:0] speed_ref_o;
   logic irq_o;
   logic [31:0] rd;
   int mismatches = 0;
   int checks_done = 0;

   always #2 clk_i = ~clk_i;

   far_side_model partner (.clk_i(clk_i), .monitor_o(monitor_i), .manual_o(manual_i));

   drive_fault_policy_unit #(.ADDR_W(8)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .monitor_i(monitor_i), .manual_i(manual_i),
      .ref_speed_i(ref_speed_i), .stop_cmd_o(stop_cmd_o), .warn_o(warn_o), .fault_o(fault_o),
      .mains_missing_o(mains_missing_o), .speed_ref_o(speed_ref_o), .irq_o(irq_o)
   );

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask : chk

   task automatic ticks(input int n);
      repeat (n) @(posedge clk_i);
   endtask : ticks

   // The request stands until ack is sampled high; a missing ack is reported after 20 edges.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      chk("bus ack", 32'h1, 32'(wb_ack_o));
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb

   task automatic cfg_wr(input logic [16:0] v);
      wb(1'b1, CFG_OFFSET, 32'(v));
   endtask : cfg_wr

   task automatic set_cond(input int c, input logic v);
      case (c)
         0: partner.monitor_o.phase_fail <= v;
         1: partner.monitor_o.ext_trip <= v;
         2: partner.monitor_o.motor_hot <= v;
         3: partner.monitor_o.ref_lost <= v;
         4: partner.monitor_o.fan_int_lost <= v;
         default: partner.monitor_o.fan_ext_lost <= v;
      endcase
   endtask : set_cond

   task automatic pulse_cond(input int c);
      set_cond(c, 1'b1);
      ticks(3);
      set_cond(c, 1'b0);
      ticks(2);
   endtask : pulse_cond

   task automatic t_reset();
      wb(1'b0, CFG_OFFSET, 32'h0);
      chk("cfg reset", 32'(CFG_RESET), rd);
      wb(1'b0, LOSS_FREQ_OFFSET, 32'h0);
      chk("loss freq reset", 32'h0, rd);
      wb(1'b1, 8'h40, 32'hFFFFFFFF);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped read", 32'h0, rd);
      chk("stop after reset", 32'h0, 32'(stop_cmd_o));
      $display("test reset done");
   endtask : t_reset

   task automatic t_motor();
      wb(1'b1, IRQ_ENABLE_OFFSET, 32'h4);
      pulse_cond(COND_MOTOR_HOT);
      chk("motor fault", 32'h4, 32'(fault_o));
      chk("stop held", 32'h1, 32'(stop_cmd_o));
      chk("irq raised", 32'h1, 32'(irq_o));
      wb(1'b0, STATUS_OFFSET, 32'h0);
      chk("status word", (32'h4 << STS_FAULT_LSB) | (32'h1 << STS_STOP_BIT), rd);
      wb(1'b1, IRQ_ENABLE_OFFSET, 32'h0);
      chk("irq masked", 32'h0, 32'(irq_o));
      wb(1'b1, IRQ_ENABLE_OFFSET, 32'h4);
      partner.manual_o.fault_display <= 1'b0;
      partner.press(1'b1);
      chk("key without display", 32'h1, 32'(stop_cmd_o));
      partner.manual_o.fault_display <= 1'b1;
      partner.press(1'b1);
      chk("key with display", 32'h0, 32'(stop_cmd_o));
      wb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
      chk("irq status", 32'h4, rd);
      wb(1'b1, IRQ_CLEAR_OFFSET, 32'h4);
      chk("irq cleared", 32'h0, 32'(irq_o));
      $display("test motor fault done");
   endtask : t_motor

   task automatic t_sources();
      for (int m = 0; m < 8; m++) begin
         cfg_wr({CFG_RESET[16:3], m[2:0]});
         pulse_cond(COND_MOTOR_HOT);
         partner.press(1'b0);
         chk("pin clear", 32'(!m[0]), 32'(fault_o[2]));
         partner.press(1'b1);
         chk("key clear", 32'(m[1:0] == 2'b00), 32'(fault_o[2]));
         wb(1'b1, SERIAL_CMD_OFFSET, 32'h1);
         ticks(2);
         chk("serial clear", 32'(m == 0), 32'(fault_o[2]));
      end
      // A request while the condition still stands must not drop the fault.
      set_cond(COND_MOTOR_HOT, 1'b1);
      partner.press(1'b0);
      chk("trip beats clear", 32'h1, 32'(fault_o[2]));
      set_cond(COND_MOTOR_HOT, 1'b0);
      cfg_wr({5'h04, CFG_RESET[11:3], 3'b111});
      partner.press(1'b0);
      chk("auto blocks pin", 32'h1, 32'(fault_o[2]));
      partner.manual_o.auto_clear <= 5'h04;
      ticks(3);
      chk("auto clear", 32'h0, 32'(fault_o[2]));
      partner.manual_o.auto_clear <= 5'h00;
      cfg_wr(CFG_RESET);
      $display("test clear sources done");
   endtask : t_sources

   task automatic t_policy();
      int conds[4] = '{1, 2, 4, 5};
      int bits[4] = '{1, 2, 4, 4};
      int lsbs[4] = '{4, 6, 10, 10};
      logic [16:0] v;
      partner.monitor_o.ext_trip_assigned <= 1'b1;
      foreach (conds[i]) begin
         for (int p = 0; p < 3; p++) begin
            v = CFG_RESET;
            v[lsbs[i] +: 2] = p[1:0];
            cfg_wr(v);
            set_cond(conds[i], 1'b1);
            ticks(4);
            chk("warn level", 32'(p == 1), 32'(warn_o[bits[i]]));
            chk("fault level", 32'(p == 2), 32'(fault_o[bits[i]]));
            chk("stop level", 32'(p == 2), 32'(stop_cmd_o));
            set_cond(conds[i], 1'b0);
            ticks(2);
            chk("warn gone", 32'h0, 32'(warn_o));
            partner.press(1'b0);
         end
      end
      cfg_wr(CFG_RESET);
      $display("test policies done");
   endtask : t_policy

   task automatic t_phase();
      pulse_cond(COND_PHASE);
      chk("phase fault", 32'h1, 32'(fault_o));
      partner.press(1'b0);
      partner.monitor_o.dc_bus_fed <= 1'b1;
      ticks(3);
      chk("mains notice", 32'h1, 32'(mains_missing_o));
      cfg_wr(CFG_RESET & ~17'h00008);
      ticks(2);
      chk("notice removed", 32'h0, 32'(mains_missing_o));
      partner.monitor_o.dc_bus_fed <= 1'b0;
      pulse_cond(COND_PHASE);
      chk("phase disabled", 32'h0, 32'(fault_o));
      cfg_wr(CFG_RESET);
      $display("test phase done");
   endtask : t_phase

   // Speed changes as the loss appears, so a hold taken one edge late shows up.
   task automatic t_ref();
      logic [16:0] v;
      logic [15:0] exp;
      wb(1'b1, LOSS_FREQ_OFFSET, 32'h00000ABC);
      for (int r = 0; r < 4; r++) begin
         v = CFG_RESET;
         v[9:8] = r[1:0];
         cfg_wr(v);
         ref_speed_i <= 16'h1234;
         ticks(3);
         set_cond(COND_REF_LOSS, 1'b1);
         ref_speed_i <= 16'h5555;
         ticks(4);
         exp = r == 1 ? 16'h1234 : (r == 2 ? 16'h0ABC : 16'h5555);
         chk("speed on loss", 32'(exp), 32'(speed_ref_o));
         chk("ref fault", 32'(r == 3), 32'(fault_o[3]));
         set_cond(COND_REF_LOSS, 1'b0);
         partner.press(1'b0);
      end
      cfg_wr(CFG_RESET);
      $display("test reference loss done");
   endtask : t_ref

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   initial begin
      rst_i <= 1'b1;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      wb_adr_i <= 8'h00;
      wb_sel_i <= 4'h0;
      wb_dat_i <= 32'h00000000;
      ref_speed_i <= 16'h0000;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_motor();
      t_sources();
      t_policy();
      t_phase();
      t_ref();
      complete_run();
   end

   // The tests need a few hundred cycles; this limit only ends a hang.
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      complete_run();
   end
endmodule : test_drive_fault_policy_unit
